// >>> design/ledpwm_top.sv
// Behaviour
// - enable low for more than 30 ms shuts down; shorter lows do nothing
// - current level register at 0x07, 0..255, resets to 255, scales on-current
// - current level zero turns all six channels off
// - current level writes act at once, no restart
// - one dimming waveform gates all six channels together
// - internal mode duty is duty level over 255 at the timebase rate
// - duty level register at 0x00, 0..255, resets to 0xff
// - duty level zero turns all six channels off outside direct mode
// - method 0x05 at 0x01 selects internal-only dimming
// - method resets to 0x01, product dimming
// - external mode takes measured input duty at the timebase rate
// - product mode duty is duty level times measured input duty
// - direct mode channels follow the external input edge for edge
// - method 0x03 selects external dimming
// - product uses 8-bit measured duty, 16-bit product, upper byte
// - external input low longer than 30.5 ms shuts down, except in internal-only mode
`timescale 1ns/1ps
`include "ledpwm_params.svh"

module ledpwm_top #(
	parameter int EN_LOW_CYCLES  = `LEDPWM_EN_LOW_CYC,
	parameter int EXT_LOW_CYCLES = `LEDPWM_EXT_LOW_CYC
) (
	// clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       srst_i,
	// control pins
	input  wire logic       enable_i,
	input  wire logic       external_dimming_duty_i,
	input  wire logic       dimming_freq_set_pin_i,
	input  wire logic       direct_mode_i,
	// serial register port
	input  wire logic       smb_scl_i,
	input  wire logic       smb_sda_i,
	output logic            smb_sda_o,
	output logic            smb_sda_oe_o,
	// channel drive
	output logic [5:0]      led_channels_o,
	output logic [7:0]      channel_current_level_o,
	output logic            shutdown_o
);

	localparam logic [`LEDPWM_TMO_W-1:0] EN_LIM  = `LEDPWM_TMO_W'(EN_LOW_CYCLES);
	localparam logic [`LEDPWM_TMO_W-1:0] EXT_LIM = `LEDPWM_TMO_W'(EXT_LOW_CYCLES);

	ledpwm_pkg::ledpwm_top_state_t st;
	ledpwm_pkg::ledpwm_top_state_t next_st;

	ledpwm_pkg::ledpwm_regwr_t wr;
	logic [7:0]  rd_ptr;
	logic [7:0]  rd_data;
	logic        slave_oe;
	logic [7:0]  ext_duty;
	logic [15:0] product;
	logic [7:0]  level;
	logic        pwm_on;

	ledpwm_i2c_slave u_slave (
		.core_clk_i (core_clk_i),
		.srst_i     (srst_i),
		.scl_i      (smb_scl_i),
		.sda_i      (smb_sda_i),
		.sda_oe_o   (slave_oe),
		.rd_ptr_o   (rd_ptr),
		.rd_data_i  (rd_data),
		.wr_o       (wr)
	);

	ledpwm_duty_meter u_meter (
		.core_clk_i (core_clk_i),
		.srst_i     (srst_i),
		.ext_i      (external_dimming_duty_i),
		.duty_o     (ext_duty)
	);

	// register read-back, unmapped offsets read zero
	assign rd_data = (rd_ptr == `LEDPWM_OFS_DUTY)    ? st.duty_level :
			 (rd_ptr == `LEDPWM_OFS_METHOD)  ? st.method :
			 (rd_ptr == `LEDPWM_OFS_CURRENT) ? st.current_level : 8'h00;

	assign product = {8'h00, st.duty_level} * {8'h00, ext_duty};

	always_comb begin
		unique case (st.method)
			`LEDPWM_METHOD_INTERNAL: level = st.duty_level;
			`LEDPWM_METHOD_EXTERNAL: level = ext_duty;
			default:                 level = product[15:8];
		endcase
	end

	assign pwm_on = st.step < level;

	always_comb begin
		next_st = st;
		next_st.ext_q = external_dimming_duty_i;
		// register writes take effect immediately
		if (wr.en) begin
			unique case (wr.addr)
				`LEDPWM_OFS_DUTY:    next_st.duty_level = wr.data;
				`LEDPWM_OFS_METHOD:  next_st.method = wr.data;
				`LEDPWM_OFS_CURRENT: next_st.current_level = wr.data;
				default: ;
			endcase
		end
		// timebase steps the dimming period
		if (dimming_freq_set_pin_i) begin
			next_st.step = (st.step == `LEDPWM_LAST_STEP) ? 8'h00 : st.step + 8'h01;
		end
		// enable low timeout
		if (enable_i) begin
			next_st.en_cnt = '0;
			next_st.en_off = 1'b0;
		end else if (st.en_cnt == EN_LIM) begin
			next_st.en_off = 1'b1;
		end else begin
			next_st.en_cnt = st.en_cnt + `LEDPWM_TMO_W'(1);
		end
		// external input low timeout, not watched in internal-only mode
		if (external_dimming_duty_i || st.method == `LEDPWM_METHOD_INTERNAL) begin
			next_st.ext_cnt = '0;
			next_st.ext_off = 1'b0;
		end else if (st.ext_cnt == EXT_LIM) begin
			next_st.ext_off = 1'b1;
		end else begin
			next_st.ext_cnt = st.ext_cnt + `LEDPWM_TMO_W'(1);
		end
		// device shut down by enable loses its settings
		if (st.en_off) begin
			next_st.duty_level = `LEDPWM_RST_DUTY;
			next_st.method = `LEDPWM_RST_METHOD;
			next_st.current_level = `LEDPWM_RST_CURRENT;
		end
		// channel gating, all six alike
		if (st.en_off || st.ext_off || st.current_level == 8'h00) begin
			next_st.led = 6'h00;
		end else if (direct_mode_i) begin
			next_st.led = {6{external_dimming_duty_i}};
		end else if (st.duty_level == 8'h00) begin
			next_st.led = 6'h00;
		end else begin
			next_st.led = {6{pwm_on}};
		end
		next_st.shutdown = st.en_off || st.ext_off;
		next_st.sda_oe = slave_oe;
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			st <= '{duty_level: `LEDPWM_RST_DUTY, method: `LEDPWM_RST_METHOD,
				current_level: `LEDPWM_RST_CURRENT, default: '0};
		end else begin
			st <= next_st;
		end
	end

	assign led_channels_o          = st.led;
	assign channel_current_level_o = st.current_level;
	assign shutdown_o              = st.shutdown;
	assign smb_sda_oe_o            = st.sda_oe;
	assign smb_sda_o               = 1'b0;

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (srst_i);

	logic run_ok;
	assign run_ok = !st.en_off && !st.ext_off && st.current_level != 8'h00 && !direct_mode_i;

	chk_reset_values: assert property (
		disable iff (1'b0) srst_i |=> (st.duty_level == 8'hff && st.method == 8'h01
			&& channel_current_level_o == 8'hff))
		else $error("register reset values wrong");

	chk_en_shutdown: assert property (
		(!enable_i && st.en_cnt == EN_LIM) |=> ##1 shutdown_o && led_channels_o == 6'h00)
		else $error("no shutdown after long enable low");

	chk_en_no_early: assert property (
		(!enable_i && st.en_cnt < EN_LIM) |=> !st.en_off)
		else $error("shutdown after short enable low");

	chk_ext_shutdown: assert property (
		(!external_dimming_duty_i && st.method != 8'h05 && st.ext_cnt == EXT_LIM)
		|=> ##1 shutdown_o)
		else $error("no shutdown after long external low");

	chk_current_zero_off: assert property (
		(st.current_level == 8'h00) |=> led_channels_o == 6'h00)
		else $error("channels on with zero current level");

	chk_current_live: assert property (
		(wr.en && wr.addr == 8'h07 && !st.en_off) |=> channel_current_level_o == $past(wr.data))
		else $error("current level write not applied");

	chk_duty_zero_off: assert property (
		(st.duty_level == 8'h00 && !direct_mode_i) |=> led_channels_o == 6'h00)
		else $error("channels on with zero duty level");

	chk_channels_alike: assert property (
		led_channels_o == 6'h00 || led_channels_o == 6'h3f)
		else $error("channels not gated together");

	chk_internal_duty: assert property (
		(run_ok && st.duty_level != 8'h00 && st.method == 8'h05)
		|=> led_channels_o == {6{$past(st.step) < $past(st.duty_level)}})
		else $error("internal duty wrong");

	chk_external_duty: assert property (
		(run_ok && st.duty_level != 8'h00 && st.method == 8'h03 && st.step >= ext_duty)
		|=> led_channels_o == 6'h00)
		else $error("external duty wrong");

	chk_product_duty: assert property (
		(run_ok && st.duty_level != 8'h00 && st.method == 8'h01 && {8'h00, st.step} < ((
		{8'h00, st.duty_level} * {8'h00, ext_duty}) >> 8)) |=> led_channels_o == 6'h3f)
		else $error("product duty wrong");

	chk_direct_follow: assert property (
		(direct_mode_i && !st.en_off && !st.ext_off && st.current_level != 8'h00)
		|=> led_channels_o == {6{$past(external_dimming_duty_i)}})
		else $error("direct mode not following input");

	chk_step_wrap: assert property (
		(dimming_freq_set_pin_i && st.step == 8'hfe) |=> st.step == 8'h00)
		else $error("period counter wrap wrong");

	cov_direct_pulse: cover property (direct_mode_i && $rose(led_channels_o[0]));
	cov_product_on: cover property (st.method == 8'h01 && led_channels_o == 6'h3f);
	cov_shutdown: cover property ($rose(shutdown_o));
	cov_reg_write: cover property (wr.en && wr.addr == 8'h07);

endmodule

// >>> pkg/ledpwm_params.svh
`ifndef LEDPWM_PARAMS_SVH
`define LEDPWM_PARAMS_SVH

// register offsets
`define LEDPWM_OFS_DUTY      8'h00
`define LEDPWM_OFS_METHOD    8'h01
`define LEDPWM_OFS_CURRENT   8'h07

// reset values
`define LEDPWM_RST_DUTY      8'hff
`define LEDPWM_RST_METHOD    8'h01
`define LEDPWM_RST_CURRENT   8'hff
`define LEDPWM_RST_EXT_DUTY  8'h00

// dimming method codes
`define LEDPWM_METHOD_PRODUCT  8'h01
`define LEDPWM_METHOD_EXTERNAL 8'h03
`define LEDPWM_METHOD_INTERNAL 8'h05

// duty period: 255 steps, counter runs 0..254
`define LEDPWM_LAST_STEP     8'hfe
`define LEDPWM_FULL_DUTY     8'hff

// clock and timeouts
`define LEDPWM_CLK_MHZ       200
`define LEDPWM_EN_LOW_US     30000
`define LEDPWM_EXT_LOW_US    30500
`define LEDPWM_EN_LOW_CYC    (`LEDPWM_EN_LOW_US * `LEDPWM_CLK_MHZ)
`define LEDPWM_EXT_LOW_CYC   (`LEDPWM_EXT_LOW_US * `LEDPWM_CLK_MHZ)
`define LEDPWM_TMO_W         23

// duty meter
`define LEDPWM_METER_W       21
`define LEDPWM_DIV_STEPS     4'h8

// serial slave
`define LEDPWM_DEV_ADDR      7'h2c
`define LEDPWM_BITS_PER_BYTE 4'h8

`endif

// >>> pkg/ledpwm_pkg.sv
`include "ledpwm_params.svh"

package ledpwm_pkg;

	typedef enum logic [2:0] {
		ledpwm_i2c_idle,
		ledpwm_i2c_addr,
		ledpwm_i2c_reg,
		ledpwm_i2c_wdata,
		ledpwm_i2c_rdata,
		ledpwm_i2c_rack,
		ledpwm_i2c_ack
	} ledpwm_i2c_st_t;

	typedef struct packed {
		logic       en;
		logic [7:0] addr;
		logic [7:0] data;
	} ledpwm_regwr_t;

	typedef struct packed {
		ledpwm_i2c_st_t st;
		ledpwm_i2c_st_t after_ack;
		logic           scl_q;
		logic           sda_q;
		logic [3:0]     bitcnt;
		logic [7:0]     shreg;
		logic [7:0]     ptr;
		logic           ack;
		logic           sda_oe;
		ledpwm_regwr_t  wr;
	} ledpwm_i2c_state_t;

	typedef struct packed {
		logic                       in_q;
		logic [`LEDPWM_METER_W-1:0] per_cnt;
		logic [`LEDPWM_METER_W-1:0] hi_cnt;
		logic [`LEDPWM_METER_W:0]   div_rem;
		logic [`LEDPWM_METER_W-1:0] div_den;
		logic [7:0]                 div_q;
		logic [3:0]                 div_step;
		logic [7:0]                 duty;
	} ledpwm_meter_state_t;

	typedef struct packed {
		logic [7:0]               duty_level;
		logic [7:0]               method;
		logic [7:0]               current_level;
		logic [7:0]               step;
		logic [`LEDPWM_TMO_W-1:0] en_cnt;
		logic [`LEDPWM_TMO_W-1:0] ext_cnt;
		logic                     en_off;
		logic                     ext_off;
		logic                     ext_q;
		logic [5:0]               led;
		logic                     shutdown;
		logic                     sda_oe;
	} ledpwm_top_state_t;

endpackage

// >>> design/ledpwm_i2c_slave.sv
`timescale 1ns/1ps
`include "ledpwm_params.svh"

module ledpwm_i2c_slave (
	// clock and reset
	input  wire logic                  core_clk_i,
	input  wire logic                  srst_i,
	// serial pins, sampled
	input  wire logic                  scl_i,
	input  wire logic                  sda_i,
	output logic                       sda_oe_o,
	// register side
	output logic [7:0]                 rd_ptr_o,
	input  wire logic [7:0]            rd_data_i,
	output ledpwm_pkg::ledpwm_regwr_t  wr_o
);

	ledpwm_pkg::ledpwm_i2c_state_t s;
	ledpwm_pkg::ledpwm_i2c_state_t next_s;

	logic start_ev;
	logic stop_ev;
	logic rise_ev;
	logic fall_ev;

	assign start_ev = s.scl_q && scl_i && s.sda_q && !sda_i;
	assign stop_ev  = s.scl_q && scl_i && !s.sda_q && sda_i;
	assign rise_ev  = !s.scl_q && scl_i;
	assign fall_ev  = s.scl_q && !scl_i;

	always_comb begin
		next_s = s;
		next_s.wr.en = 1'b0;
		next_s.scl_q = scl_i;
		next_s.sda_q = sda_i;
		if (start_ev) begin
			next_s.st = ledpwm_pkg::ledpwm_i2c_addr;
			next_s.bitcnt = 4'h0;
			next_s.sda_oe = 1'b0;
		end else if (stop_ev) begin
			next_s.st = ledpwm_pkg::ledpwm_i2c_idle;
			next_s.sda_oe = 1'b0;
		end else begin
			unique case (s.st)
				ledpwm_pkg::ledpwm_i2c_idle: begin
				end
				ledpwm_pkg::ledpwm_i2c_addr,
				ledpwm_pkg::ledpwm_i2c_reg,
				ledpwm_pkg::ledpwm_i2c_wdata: begin
					if (rise_ev) begin
						next_s.shreg = {s.shreg[6:0], sda_i};
						next_s.bitcnt = s.bitcnt + 4'h1;
					end else if (fall_ev && s.bitcnt == `LEDPWM_BITS_PER_BYTE) begin
						next_s.bitcnt = 4'h0;
						next_s.sda_oe = 1'b1;
						next_s.st = ledpwm_pkg::ledpwm_i2c_ack;
						if (s.st == ledpwm_pkg::ledpwm_i2c_addr) begin
							if (s.shreg[7:1] != `LEDPWM_DEV_ADDR) begin
								next_s.sda_oe = 1'b0;
								next_s.st = ledpwm_pkg::ledpwm_i2c_idle;
							end else if (s.shreg[0]) begin
								next_s.after_ack = ledpwm_pkg::ledpwm_i2c_rdata;
							end else begin
								next_s.after_ack = ledpwm_pkg::ledpwm_i2c_reg;
							end
						end else if (s.st == ledpwm_pkg::ledpwm_i2c_reg) begin
							next_s.ptr = s.shreg;
							next_s.after_ack = ledpwm_pkg::ledpwm_i2c_wdata;
						end else begin
							next_s.wr = '{en: 1'b1, addr: s.ptr, data: s.shreg};
							next_s.ptr = s.ptr + 8'h01;
							next_s.after_ack = ledpwm_pkg::ledpwm_i2c_wdata;
						end
					end
				end
				ledpwm_pkg::ledpwm_i2c_ack: begin
					if (fall_ev) begin
						next_s.bitcnt = 4'h0;
						if (s.after_ack == ledpwm_pkg::ledpwm_i2c_rdata) begin
							next_s.shreg = rd_data_i;
							next_s.sda_oe = !rd_data_i[7];
							next_s.ptr = s.ptr + 8'h01;
						end else begin
							next_s.sda_oe = 1'b0;
						end
						next_s.st = s.after_ack;
					end
				end
				ledpwm_pkg::ledpwm_i2c_rdata: begin
					if (rise_ev) begin
						next_s.bitcnt = s.bitcnt + 4'h1;
					end else if (fall_ev) begin
						if (s.bitcnt == `LEDPWM_BITS_PER_BYTE) begin
							next_s.sda_oe = 1'b0;
							next_s.st = ledpwm_pkg::ledpwm_i2c_rack;
						end else begin
							next_s.shreg = {s.shreg[6:0], 1'b0};
							next_s.sda_oe = !s.shreg[6];
						end
					end
				end
				ledpwm_pkg::ledpwm_i2c_rack: begin
					if (rise_ev) begin
						next_s.ack = !sda_i;
					end else if (fall_ev) begin
						if (s.ack) begin
							next_s.bitcnt = 4'h0;
							next_s.shreg = rd_data_i;
							next_s.sda_oe = !rd_data_i[7];
							next_s.ptr = s.ptr + 8'h01;
							next_s.st = ledpwm_pkg::ledpwm_i2c_rdata;
						end else begin
							next_s.st = ledpwm_pkg::ledpwm_i2c_idle;
						end
					end
				end
				default: begin
					next_s.st = ledpwm_pkg::ledpwm_i2c_idle;
					next_s.sda_oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			s <= '{st: ledpwm_pkg::ledpwm_i2c_idle, after_ack: ledpwm_pkg::ledpwm_i2c_idle,
				scl_q: 1'b1, sda_q: 1'b1, default: '0};
		end else begin
			s <= next_s;
		end
	end

	assign sda_oe_o = s.sda_oe;
	assign rd_ptr_o = s.ptr;
	assign wr_o     = s.wr;

endmodule

// >>> design/ledpwm_duty_meter.sv
`timescale 1ns/1ps
`include "ledpwm_params.svh"

module ledpwm_duty_meter (
	// clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       srst_i,
	// external dimming input
	input  wire logic       ext_i,
	// measured duty, 255 = always high
	output logic [7:0]      duty_o
);

	localparam logic [`LEDPWM_METER_W-1:0] CNT_MAX = '1;

	ledpwm_pkg::ledpwm_meter_state_t s;
	ledpwm_pkg::ledpwm_meter_state_t next_s;

	logic [`LEDPWM_METER_W:0] rem2;

	always_comb begin
		next_s = s;
		next_s.in_q = ext_i;
		rem2 = {s.div_rem[`LEDPWM_METER_W-1:0], 1'b0};
		// high time over period, one quotient bit per cycle
		if (s.div_step != 4'h0) begin
			if (rem2 >= {1'b0, s.div_den}) begin
				next_s.div_rem = rem2 - {1'b0, s.div_den};
				next_s.div_q = {s.div_q[6:0], 1'b1};
			end else begin
				next_s.div_rem = rem2;
				next_s.div_q = {s.div_q[6:0], 1'b0};
			end
			next_s.div_step = s.div_step - 4'h1;
			if (s.div_step == 4'h1) begin
				next_s.duty = next_s.div_q;
			end
		end
		if (ext_i && !s.in_q) begin
			if (s.div_step == 4'h0 && s.per_cnt != '0) begin
				next_s.div_rem = {1'b0, s.hi_cnt};
				next_s.div_den = s.per_cnt;
				next_s.div_q = 8'h00;
				next_s.div_step = `LEDPWM_DIV_STEPS;
			end
			next_s.per_cnt = `LEDPWM_METER_W'(1);
			next_s.hi_cnt = `LEDPWM_METER_W'(1);
		end else if (s.per_cnt == CNT_MAX) begin
			// no rising edge for a whole window: input is static
			next_s.duty = ext_i ? `LEDPWM_FULL_DUTY : 8'h00;
		end else begin
			next_s.per_cnt = s.per_cnt + `LEDPWM_METER_W'(1);
			next_s.hi_cnt = s.hi_cnt + `LEDPWM_METER_W'(ext_i);
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			s <= '{duty: `LEDPWM_RST_EXT_DUTY, default: '0};
		end else begin
			s <= next_s;
		end
	end

	assign duty_o = s.duty;

endmodule

// >>> dv/ledpwm_host_model.sv
`timescale 1ns/1ps
`include "ledpwm_params.svh"

module ledpwm_host_model (
	// clock
	input  wire logic core_clk_i,
	// serial bus, wire level seen by all parties
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_o,
	// external dimming source
	output logic      ext_o
);
	int ext_per = 128;
	int ext_hi  = 96;
	int ext_cnt = 0;

	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
		ext_o = 1'b0;
	end

	// free-running source; low phases stay short of the shutdown window at the default 128/96 setting
	always @(negedge core_clk_i) begin
		ext_cnt = (ext_cnt + 1 >= ext_per) ? 0 : ext_cnt + 1;
		ext_o <= (ext_cnt < ext_hi);
	end

	task automatic set_ext(input int per, input int hi);
		ext_per = per;
		ext_hi  = hi;
	endtask

	// each phase lasts three cycles, all changes at the falling clock edge
	task automatic drive(input logic c, input logic d);
		scl_o = c;
		sda_o = d;
		repeat (3) @(negedge core_clk_i);
	endtask

	// scl is dropped first so a repeated start never looks like a stop
	task automatic start_cond();
		drive(1'b0, sda_o);
		drive(1'b0, 1'b1);
		drive(1'b1, 1'b1);
		drive(1'b1, 1'b0);
	endtask

	task automatic stop_cond();
		drive(1'b0, sda_o);
		drive(1'b0, 1'b0);
		drive(1'b1, 1'b0);
		drive(1'b1, 1'b1);
	endtask

	// nine bits msb first; the last bit is the acknowledge slot
	task automatic xfer(input logic [8:0] o, output logic [8:0] r);
		for (int i = 8; i >= 0; i--) begin
			drive(1'b0, sda_o);
			drive(1'b0, o[i]);
			drive(1'b1, o[i]);
			r[i] = sda_i;
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
		logic [8:0] r0, r1, r2;
		start_cond();
		xfer({`LEDPWM_DEV_ADDR, 1'b0, 1'b1}, r0);
		xfer({a, 1'b1}, r1);
		xfer({d, 1'b1}, r2);
		stop_cond();
		ok = ~r0[0] & ~r1[0] & ~r2[0];
	endtask

	// read ends with a released acknowledge slot, then stop
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
		logic [8:0] r0, r1, r2, r3;
		start_cond();
		xfer({`LEDPWM_DEV_ADDR, 1'b0, 1'b1}, r0);
		xfer({a, 1'b1}, r1);
		start_cond();
		xfer({`LEDPWM_DEV_ADDR, 1'b1, 1'b1}, r2);
		xfer(9'h1ff, r3);
		stop_cond();
		d  = r3[8:1];
		ok = ~r0[0] & ~r1[0] & ~r2[0];
	endtask
endmodule

// >>> dv/led_pwm_dimming_control_tb.sv
`timescale 1ns/1ps

module led_pwm_dimming_control_tb;
	localparam int EN_LOW  = 50;
	localparam int EXT_LOW = 60;
	localparam int PERIOD  = 510;

	logic       core_clk = 1'b0;
	logic       srst     = 1'b1;
	logic       enable   = 1'b1;
	logic       tick     = 1'b0;
	logic       direct   = 1'b0;
	logic       scl;
	logic       host_sda;
	logic       ext;
	logic       sda_oe;
	logic [5:0] led;
	logic [7:0] cur_lvl;
	logic       shutdown;
	logic       sda_out;
	wire        sda_wire = host_sda & ~(sda_oe & ~sda_out);
	int         fails = 0;
	int         num_checks = 0;

	always #2.5 core_clk = ~core_clk;

	// one timebase pulse every second cycle
	always @(negedge core_clk) tick <= ~tick;

	ledpwm_top #(
		.EN_LOW_CYCLES (EN_LOW),
		.EXT_LOW_CYCLES(EXT_LOW)
	) dut_u (
		.core_clk_i             (core_clk),
		.srst_i                 (srst),
		.enable_i               (enable),
		.external_dimming_duty_i(ext),
		.dimming_freq_set_pin_i (tick),
		.direct_mode_i          (direct),
		.smb_scl_i              (scl),
		.smb_sda_i              (sda_wire),
		.smb_sda_o              (sda_out),
		.smb_sda_oe_o           (sda_oe),
		.led_channels_o         (led),
		.channel_current_level_o(cur_lvl),
		.shutdown_o             (shutdown)
	);

	ledpwm_host_model host_u (
		.core_clk_i(core_clk),
		.sda_i     (sda_wire),
		.scl_o     (scl),
		.sda_o     (host_sda),
		.ext_o     (ext)
	);

	task automatic stop_test();
		if (fails == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp, input string what);
		chk_byte({7'h00, got}, {7'h00, exp}, what);
	endtask

	task automatic chk_cnt(input int got, input int exp, input string what);
		num_checks++;
		if (got != exp) begin
			fails++;
			$display("[ERR] %0t %s got %0d exp %0d", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic ok;
		host_u.wr_reg(a, d, ok);
		chk_bit(ok, 1'b1, "write ack");
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic       ok;
		host_u.rd_reg(a, d, ok);
		chk_bit(ok, 1'b1, "read ack");
		chk_byte(d, exp, "read data");
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	// settle one dimming period, then count on cycles over the next one
	task automatic duty_chk(input int lvl, input string what);
		int n;
		n = 0;
		cyc(PERIOD);
		repeat (PERIOD) begin
			cyc(1);
			if (led === 6'h3f) n++;
			else if (led !== 6'h00) chk_byte({2'h0, led}, 8'h3f, "channels split");
		end
		chk_cnt(n, 2 * lvl, what);
	endtask

	initial begin
		cyc(100000);
		chk_bit(1'b1, 1'b0, "timeout");
		stop_test();
	end

	initial begin
		logic [7:0] meth [3];
		int         lvl [3];
		meth = '{8'h01, 8'h03, 8'h05};
		lvl  = '{96, 192, 128};
		repeat (20) @(negedge core_clk);
		srst = 1'b0;
		chk_byte(cur_lvl, 8'hff, "current out at reset");
		chk_bit(shutdown, 1'b0, "shutdown at reset");
		rd(8'h00, 8'hff);
		rd(8'h01, 8'h01);
		rd(8'h07, 8'hff);
		wr(8'h02, 8'h5a);
		rd(8'h02, 8'h00);
		duty_chk(191, "product at reset");
		wr(8'h00, 8'h80);
		for (int i = 0; i < 3; i++) begin
			wr(8'h01, meth[i]);
			rd(8'h01, meth[i]);
			duty_chk(lvl[i], "method duty");
		end
		wr(8'h00, 8'h00);
		duty_chk(0, "duty zero");
		wr(8'h00, 8'h80);
		wr(8'h07, 8'hc8);
		chk_byte(cur_lvl, 8'hc8, "current out");
		rd(8'h07, 8'hc8);
		duty_chk(128, "current write on the fly");
		wr(8'h07, 8'h00);
		chk_byte(cur_lvl, 8'h00, "current out zero");
		duty_chk(0, "current zero");
		wr(8'h07, 8'hff);
		@(negedge core_clk);
		direct = 1'b1;
		host_u.set_ext(6, 2);
		cyc(10);
		repeat (60) begin
			cyc(1);
			chk_byte({2'h0, led}, {2'h0, {6{ext}}}, "direct follow");
		end
		@(negedge core_clk);
		direct = 1'b0;
		host_u.set_ext(128, 96);
		wr(8'h01, 8'h03);
		host_u.set_ext(128, 128);
		cyc(4);
		@(negedge core_clk);
		host_u.set_ext(128, 0);
		cyc(40);
		chk_bit(shutdown, 1'b0, "short ext low");
		cyc(40);
		chk_bit(shutdown, 1'b1, "long ext low");
		chk_byte({2'h0, led}, 8'h00, "off in shutdown");
		host_u.set_ext(128, 128);
		cyc(10);
		chk_bit(shutdown, 1'b0, "ext recovered");
		@(negedge core_clk);
		enable = 1'b0;
		cyc(40);
		chk_bit(shutdown, 1'b0, "short enable low");
		@(negedge core_clk);
		enable = 1'b1;
		cyc(5);
		@(negedge core_clk);
		enable = 1'b0;
		cyc(60);
		chk_bit(shutdown, 1'b1, "long enable low");
		chk_byte({2'h0, led}, 8'h00, "off in shutdown");
		@(negedge core_clk);
		enable = 1'b1;
		cyc(5);
		chk_bit(shutdown, 1'b0, "enable recovered");
		rd(8'h00, 8'hff);
		rd(8'h01, 8'h01);
		stop_test();
	end
endmodule
